// File: rtl/dtg_pkg.sv
// Package for the dual-tone generator register block.
// Assumes a byte-wide register port in the controller's data space.
package dtg_pkg;
  localparam logic [15:0] DTG_BASE = 16'hFF50;
  localparam logic [15:0] DTG_T1F1 = 16'hFF50;
  localparam logic [15:0] DTG_T1F2 = 16'hFF51;
  localparam logic [15:0] DTG_T1F3 = 16'hFF52;
  localparam logic [15:0] DTG_T1AMP = 16'hFF53;
  localparam logic [15:0] DTG_HOLE = 16'hFF54;
  localparam logic [15:0] DTG_T2F1 = 16'hFF55;
  localparam logic [15:0] DTG_T2F2 = 16'hFF56;
  localparam logic [15:0] DTG_T2F3 = 16'hFF57;
  localparam logic [15:0] DTG_T2AMP = 16'hFF58;
  localparam logic [15:0] DTG_COMMIT = 16'hFF59;
  localparam int DTG_NLOC = 10;
  localparam logic [7:0] DTG_CODE_MAX = 8'h7F;
  localparam logic [7:0] DTG_ZERO = 8'h00;
  localparam logic [3:0] DTG_IDX_T1AMP = 4'h3;
  localparam logic [3:0] DTG_IDX_T2AMP = 4'h8;
  localparam logic [3:0] DTG_IDX_COMMIT = 4'h9;

  typedef struct packed {
    logic [23:0] t1_freq;
    logic [7:0] t1_amp;
    logic [23:0] t2_freq;
    logic [7:0] t2_amp;
    logic [7:0] rx_atten;
  } dtg_coef_t;
endpackage

// File: rtl/dtg_stage_mem.sv
// Staging byte store for the generator locations.
// Assumes one write port and a registered read port on the same clock.
`timescale 1ns/1ns
module dtg_stage_mem #(
  parameter int DEPTH = 10
) (
  input wire logic clock,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic re,
  input wire logic [3:0] raddr,
  output logic [7:0] rdata_q,
  output logic [DEPTH*8-1:0] all_q
);
  // Plain RAM: no reset, contents undefined until software writes them
  logic [7:0] mem_q [DEPTH];
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (re) begin
      rdata_d = (int'(raddr) < DEPTH) ? mem_q[raddr] : 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    rdata_q <= rdata_d;
    if (we && int'(waddr) < DEPTH) begin
      mem_q[waddr] <= wdata;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_flat
      assign all_q[gi*8 +: 8] = mem_q[gi];
    end
  endgenerate
endmodule // dtg_stage_mem

// File: rtl/dtg_regs.sv
// Dual-tone generator register block: staged bytes, commit, tone mix.
// Assumes a sine source elsewhere supplies the raw tone samples and the
// codec low-pass stage follows the receive tone output.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
module dtg_regs
  import dtg_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic signed [SAMPLE_W-1:0] tone1_raw,
  input wire logic signed [SAMPLE_W-1:0] tone2_raw,
  output logic [23:0] tone1_freq,
  output logic [23:0] tone2_freq,
  output logic commit_pulse,
  output logic signed [SAMPLE_W-1:0] rx_tone_q
);
  ////////////////////////////////////////////////////////////////////////
  // Address decode
  logic hit;
  logic [3:0] idx;
  logic [15:0] offs;
  logic rd_hit_q;
  logic rd_hit_d;
  logic [7:0] mem_rdata;
  logic [DTG_NLOC*8-1:0] staged;

  assign offs = reg_addr - DTG_BASE;
  // FF54 belongs to the transmit path, not this block
  assign hit = (reg_addr >= DTG_T1F1) && (reg_addr <= DTG_COMMIT) && (reg_addr != DTG_HOLE);
  assign idx = offs[3:0];

  dtg_stage_mem #(.DEPTH(DTG_NLOC)) u_stage (
    .clock(clock),
    .we(reg_wr && hit),
    .waddr(idx),
    .wdata(reg_wdata),
    .re(reg_rd && hit),
    .raddr(idx),
    .rdata_q(mem_rdata),
    .all_q(staged)
  );

  // Unmapped reads return zero
  assign rd_hit_d = reg_rd ? hit : rd_hit_q;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_hit_q <= 1'b0;
    end else begin
      rd_hit_q <= rd_hit_d;
    end
  end
  assign reg_rdata = rd_hit_q ? mem_rdata : DTG_ZERO;

  ////////////////////////////////////////////////////////////////////////
  // Commit: the write to FF59 carries its own new byte into the active set
  dtg_coef_t act_q;
  dtg_coef_t act_d;
  logic commit;
  logic commit_q;
  logic [7:0] wb [DTG_NLOC];

  assign commit = reg_wr && (reg_addr == DTG_COMMIT);

  genvar gi;
  generate
    for (gi = 0; gi < DTG_NLOC; gi++) begin : g_byte
      assign wb[gi] = (commit && idx == 4'(gi)) ? reg_wdata : staged[gi*8 +: 8];
    end
  endgenerate

  always_comb begin
    act_d = act_q;
    if (commit) begin
      act_d.t1_freq = {wb[0], wb[1], wb[2]};
      act_d.t1_amp = wb[DTG_IDX_T1AMP];
      act_d.t2_freq = {wb[5], wb[6], wb[7]};
      act_d.t2_amp = wb[DTG_IDX_T2AMP];
      act_d.rx_atten = wb[DTG_IDX_COMMIT];
    end
  end

  // Active set is RAM-like with no defined reset value
  always_ff @(posedge clock) begin
    act_q <= act_d;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      commit_q <= 1'b0;
    end else begin
      commit_q <= commit;
    end
  end

  // The active set is unknown until software has committed at least once
  logic act_valid_q;
  logic act_valid_d;

  always_comb begin
    act_valid_d = act_valid_q;
    if (commit) begin
      act_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      act_valid_q <= 1'b0;
    end else begin
      act_valid_q <= act_valid_d;
    end
  end

  assign tone1_freq = act_q.t1_freq;
  assign tone2_freq = act_q.t2_freq;
  assign commit_pulse = commit_q;

  ////////////////////////////////////////////////////////////////////////
  // Mix. Gain is linear code/128: 00 silent, 40 half, 7F near unity.
  // Bit 7 of a code is ignored; only 00..7F are valid.
  function automatic logic signed [SAMPLE_W+8:0] dtg_scale(
    input logic signed [SAMPLE_W+1:0] s,
    input logic [7:0] code
  );
    logic signed [SAMPLE_W+9:0] p;
    p = s * $signed({2'b00, code[6:0]});
    return p[SAMPLE_W+9:1];
  endfunction

  logic signed [SAMPLE_W+8:0] t1_s;
  logic signed [SAMPLE_W+8:0] t2_s;
  logic signed [SAMPLE_W+1:0] sum;
  logic signed [SAMPLE_W+8:0] rx_s;
  logic signed [SAMPLE_W-1:0] rx_d;
  localparam logic signed [SAMPLE_W+8:0] SAT_HI = (SAMPLE_W+9)'(2**(SAMPLE_W-1)-1);
  localparam logic signed [SAMPLE_W+8:0] SAT_LO = -SAT_HI - (SAMPLE_W+9)'(1);

  always_comb begin
    t1_s = dtg_scale({{2{tone1_raw[SAMPLE_W-1]}}, tone1_raw}, act_q.t1_amp) >>> 6;
    t2_s = dtg_scale({{2{tone2_raw[SAMPLE_W-1]}}, tone2_raw}, act_q.t2_amp) >>> 6;
    // Sum keeps two guard bits; overflow beyond them is software's concern
    sum = t1_s[SAMPLE_W+1:0] + t2_s[SAMPLE_W+1:0];
    rx_s = dtg_scale(sum, act_q.rx_atten) >>> 6;
    // Clip instead of wrapping when the programmed levels are too high
    if (rx_s > SAT_HI) begin
      rx_d = SAT_HI[SAMPLE_W-1:0];
    end else if (rx_s < SAT_LO) begin
      rx_d = SAT_LO[SAMPLE_W-1:0];
    end else begin
      rx_d = rx_s[SAMPLE_W-1:0];
    end
  end

  // Output feeds the codec low-pass stage downstream
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_tone_q <= '0;
    end else begin
      rx_tone_q <= rx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_commit_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    commit |=> commit_pulse)
    else $error("commit pulse missing");
  a_commit_load: assert property (@(posedge clock) disable iff (sys_rst)
    commit |=> act_q.rx_atten == $past(reg_wdata))
    else $error("commit byte not loaded");
  a_hold_nocommit: assert property (@(posedge clock) disable iff (sys_rst)
    act_valid_q && !commit |=> $stable(act_q))
    else $error("active set changed without commit");
  a_silent_zero: assert property (@(posedge clock) disable iff (sys_rst)
    (act_q.rx_atten[6:0] == 7'h00) |=> rx_tone_q == '0)
    else $error("code zero not silent");
  a_unmapped_read: assert property (@(posedge clock) disable iff (sys_rst)
    (reg_rd && !hit) |=> reg_rdata == DTG_ZERO)
    else $error("unmapped read not zero");
  a_freq_bytes: assert property (@(posedge clock) disable iff (sys_rst)
    commit |=> tone2_freq[7:0] == $past(wb[7]))
    else $error("tone two low byte wrong");

  sequence s_mapped_read;
    reg_rd && hit;
  endsequence

  sequence s_mute_commit;
    commit ##0 (reg_wdata[6:0] == 7'h00);
  endsequence

  a_read_staged: assert property (@(posedge clock) disable iff (sys_rst)
    s_mapped_read |=> reg_rdata == $past(staged[idx*8 +: 8]))
    else $error("read did not return staged byte");
  a_commit_mute: assert property (@(posedge clock) disable iff (sys_rst)
    s_mute_commit |=> ##1 rx_tone_q == '0)
    else $error("zero commit code not silent");
  a_clip_high: assert property (@(posedge clock) disable iff (sys_rst)
    (rx_s > SAT_HI) |=> rx_tone_q == SAT_HI[SAMPLE_W-1:0])
    else $error("positive overflow not clipped");
  a_clip_low: assert property (@(posedge clock) disable iff (sys_rst)
    (rx_s < SAT_LO) |=> rx_tone_q == SAT_LO[SAMPLE_W-1:0])
    else $error("negative overflow not clipped");
  a_pulse_origin: assert property (@(posedge clock) disable iff (sys_rst)
    commit_pulse |-> $past(commit))
    else $error("commit pulse without commit write");
endmodule // dtg_regs

// File: sim/dtg_regs_bench.sv
// Self-checking bench for the dual-tone generator register block.
// Assumes the byte register port of the block and a 50 MHz clock.
`timescale 1ns/1ns
module dtg_regs_bench;
  import dtg_pkg::*;
  logic clock, sys_rst, reg_wr, reg_rd, commit_pulse;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rb;
  logic signed [15:0] tone1_raw, tone2_raw, rx_tone_q;
  logic [23:0] tone1_freq, tone2_freq;
  int num_errors, check_count;
  localparam logic [15:0] AD [8] = '{DTG_T1F1, DTG_T1F2, DTG_T1F3, DTG_T1AMP,
                                     DTG_T2F1, DTG_T2F2, DTG_T2F3, DTG_T2AMP};
  localparam logic [7:0] VD [8] = '{8'hBD, 8'h26, 8'h6D, 8'h40, 8'h98, 8'h40, 8'h4A, 8'h40};

  dtg_regs #(.SAMPLE_W(16)) uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tone1_raw(tone1_raw), .tone2_raw(tone2_raw), .tone1_freq(tone1_freq),
    .tone2_freq(tone2_freq), .commit_pulse(commit_pulse), .rx_tone_q(rx_tone_q));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic fail(input string what);
    num_errors++;
    $display("ERROR %0t %s", $time, what);
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) fail($sformatf("byte %h exp %h", got, exp));
  endtask

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) fail($sformatf("freq %h exp %h", got, exp));
  endtask

  task automatic chk_tone(input logic [15:0] exp);
    check_count++;
    if (rx_tone_q !== exp) fail($sformatf("tone %h exp %h", rx_tone_q, exp));
  endtask

  // Strobes drop one edge after rising, so back-to-back calls leave a one-cycle gap
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic step;
    @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    fail("timeout");
    test_done;
  end

  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    tone1_raw = 16'sh1000;
    tone2_raw = 16'sh0800;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) wr(AD[i], VD[i]);
    for (int i = 0; i < 8; i++) begin
      rd(AD[i], rb);
      chk_byte(rb, VD[i]);
    end
    wr(DTG_COMMIT, 8'h40);
    chk_byte({7'h00, commit_pulse}, 8'h01);
    chk_word(tone1_freq, 24'hBD266D);
    chk_word(tone2_freq, 24'h98404A);
    step;
    chk_tone(16'h0600);
    chk_byte({7'h00, commit_pulse}, 8'h00);
    rd(DTG_COMMIT, rb);
    chk_byte(rb, 8'h40);
    // Restage tone one while the old set is still active
    wr(DTG_T1F1, 8'hAA);
    wr(DTG_T1F2, 8'h4D);
    wr(DTG_T1F3, 8'h5E);
    wr(DTG_T1AMP, 8'h00);
    step;
    chk_word(tone1_freq, 24'hBD266D);
    chk_tone(16'h0600);
    rd(DTG_T1F1, rb);
    chk_byte(rb, 8'hAA);
    wr(DTG_COMMIT, 8'h7F);
    chk_word(tone1_freq, 24'hAA4D5E);
    step;
    chk_tone(16'h03F8);
    wr(DTG_COMMIT, 8'h00);
    step;
    chk_tone(16'h0000);
    // Both tones near full scale ignore the headroom advice, so the output must clip
    wr(DTG_T1AMP, 8'h7F);
    wr(DTG_T2AMP, 8'h7F);
    wr(DTG_COMMIT, 8'h7F);
    @(posedge clock);
    tone1_raw <= 16'sh7FFF;
    tone2_raw <= 16'sh7FFF;
    step;
    chk_tone(16'h7FFF);
    @(posedge clock);
    tone1_raw <= 16'sh8000;
    tone2_raw <= 16'sh8000;
    step;
    chk_tone(16'h8000);
    // The transmit-tone hole and the next codec byte are not ours
    wr(DTG_HOLE, 8'h5A);
    rd(DTG_HOLE, rb);
    chk_byte(rb, 8'h00);
    rd(16'hFF5A, rb);
    chk_byte(rb, 8'h00);
    test_done;
  end
endmodule // dtg_regs_bench
